// file: inc/smr_map.svh
`ifndef SMR_MAP_SVH
`define SMR_MAP_SVH

// ============================================================
// management register addresses
`define SMR_ADDR_CONTROL      5'h00
`define SMR_ADDR_STATUS       5'h01
`define SMR_ADDR_ID_HIGH      5'h02
`define SMR_ADDR_ID_LOW       5'h03
`define SMR_ADDR_ADVERT       5'h04
`define SMR_ADDR_EXT_STATUS   5'h0F
`define SMR_ADDR_IRQ_CONTROL  5'h10

// ============================================================
// control register field positions
`define SMR_CTL_RESET         15
`define SMR_CTL_LOOPBACK      14
`define SMR_CTL_SPEED_LSB     13
`define SMR_CTL_AN_ENABLE     12
`define SMR_CTL_POWER_DOWN    11
`define SMR_CTL_ISOLATE       10
`define SMR_CTL_AN_RESTART    9
`define SMR_CTL_DUPLEX        8
`define SMR_CTL_COL_TEST      7
`define SMR_CTL_SPEED_MSB     6
`define SMR_CTL_UNIDIR        5

// ============================================================
// interrupt control field positions
`define SMR_IRQ_STATUS        1
`define SMR_IRQ_ENABLE        0

// ============================================================
// reset values of stored bits
`define SMR_RST_LOOPBACK      1'b0
`define SMR_RST_AN_ENABLE     1'b1
`define SMR_RST_POWER_DOWN    1'b0
`define SMR_RST_ISOLATE       1'b1
`define SMR_RST_UNIDIR        1'b0
`define SMR_RST_IRQ_ENABLE    1'b1
`define SMR_RST_IRQ_STATUS    1'b0

// ============================================================
// fixed read values
`define SMR_VAL_SPEED_LSB     1'b0
`define SMR_VAL_SPEED_MSB     1'b1
`define SMR_VAL_DUPLEX        1'b1
`define SMR_VAL_COL_TEST      1'b0
`define SMR_VAL_STATUS        16'h01C0
`define SMR_STATUS_LINK       2
`define SMR_VAL_ADVERT        16'h0001
`define SMR_VAL_EXT_STATUS    16'h8000
`define SMR_VAL_ZERO          16'h0000

// ============================================================
// serial management frame
`define SMR_OP_READ           2'b10
`define SMR_OP_WRITE          2'b01
`define SMR_HDR_LAST          5'h0B
`define SMR_DATA_LAST         5'h0F

`endif

// file: inc/smr_pkg.sv
package smr_pkg;

  typedef logic [4:0]  smr_addr_t;
  typedef logic [15:0] smr_word_t;

  typedef enum logic [4:0] {
    SMR_IDLE   = 5'b00001,
    SMR_START  = 5'b00010,
    SMR_HEADER = 5'b00100,
    SMR_TURN   = 5'b01000,
    SMR_DATA   = 5'b10000
  } smr_state_t;

endpackage

// file: inc/smr_pin_if.sv
`timescale 1ns/10ps

interface smr_pin_if;
  logic mdc_rise;
  logic mdio_lvl;

  modport sync (
    output mdc_rise,
    output mdio_lvl
  );

  modport engine (
    input  mdc_rise,
    input  mdio_lvl
  );
endinterface

// file: verilog/smr_pin_sync.sv
`timescale 1ns/10ps

module smr_pin_sync (
  // clock and reset
  input  wire logic clk_i,
  input  wire logic rst_b_i,
  // raw management pins
  input  wire logic mdc_i,
  input  wire logic mdio_i,
  // filtered view
  smr_pin_if.sync   pins
);
  import smr_pkg::*;

  logic [1:0] raw;
  logic [1:0] stage1;
  logic [1:0] stage2;
  logic [1:0] stage3;
  logic [1:0] filt;
  logic [1:0] next_filt;
  logic       rise;
  logic       next_rise;

  assign raw = {mdio_i, mdc_i};

  // ============================================================
  // three-stage chain per pin, level moves once stages two and three agree
  genvar g;
  for (g = 0; g < 2; g++) begin : g_pin
    always_comb begin
      next_filt[g] = (stage2[g] == stage3[g]) ? stage3[g] : filt[g];
    end

    always_ff @(posedge clk_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
        stage1[g] <= 1'b0;
        stage2[g] <= 1'b0;
        stage3[g] <= 1'b0;
        filt[g]   <= 1'b0;
      end else begin
        stage1[g] <= raw[g];
        stage2[g] <= stage1[g];
        stage3[g] <= stage2[g];
        filt[g]   <= next_filt[g];
      end
    end
  end

  // ============================================================
  // clock edge detect on the filtered level only
  always_comb begin
    next_rise = next_filt[0] & ~filt[0];
  end

  always_ff @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      rise <= 1'b0;
    end else begin
      rise <= next_rise;
    end
  end

  assign pins.mdc_rise = rise;
  // data level taken in the same cycle the filtered clock rose; data must hold past the edge
  assign pins.mdio_lvl = filt[1];

endmodule

// file: verilog/smr_mgmt_regs.sv

`timescale 1ns/10ps
`include "smr_map.svh"

module smr_mgmt_regs #(
  // identifier words; values are arbitrary
  parameter logic [15:0] ID_HIGH = 16'h0000,
  parameter logic [15:0] ID_LOW  = 16'h0000
) (
  // clock and reset
  input  wire logic              clk_i,
  input  wire logic              rst_b_i,
  // management pins
  input  wire logic              mdc_i,
  input  wire logic              mdio_i,
  output logic                   mdio_o,
  output logic                   mdio_oe_o,
  input  wire smr_pkg::smr_addr_t phyad_i,
  // core status
  input  wire logic              an_complete_i,
  input  wire logic              link_up_i,
  input  wire logic              ten_bit_parallel_option_i,
  // core control
  output logic                   core_reset_o,
  output logic                   loopback_o,
  output logic                   external_wrap_o,
  output logic                   power_down_o,
  output logic                   isolate_o,
  output logic                   an_enable_o,
  output logic                   an_restart_o,
  output logic                   unidirectional_o,
  output logic                   negotiation_done_irq_out_o
);
  import smr_pkg::*;

  // ============================================================
  // pin synchroniser
  smr_pin_if pins ();

  smr_pin_sync u_sync (
    .clk_i   (clk_i),
    .rst_b_i (rst_b_i),
    .mdc_i   (mdc_i),
    .mdio_i  (mdio_i),
    .pins    (pins)
  );

  // ============================================================
  // state declarations
  smr_state_t state;
  smr_state_t next_state;
  logic [4:0] cnt;
  logic [4:0] next_cnt;
  smr_word_t  sh;
  smr_word_t  next_sh;
  logic       is_rd;
  logic       next_is_rd;
  logic       is_wr;
  logic       next_is_wr;
  smr_addr_t  wr_addr;
  smr_addr_t  next_wr_addr;
  logic       seen_one;
  logic       next_seen_one;
  logic       mdio_out;
  logic       next_mdio_out;
  logic       mdio_oe;
  logic       next_mdio_oe;
  logic       wr_stb;
  logic       next_wr_stb;
  smr_word_t  wr_data;
  smr_word_t  next_wr_data;

  logic [11:0] hdr;
  logic        hdr_match;
  smr_word_t   rd_word;

  logic loopback;
  logic next_loopback;
  logic an_enable;
  logic next_an_enable;
  logic power_down;
  logic next_power_down;
  logic isolate;
  logic next_isolate;
  logic unidir;
  logic next_unidir;
  logic irq_enable;
  logic next_irq_enable;
  logic irq_status;
  logic next_irq_status;
  logic core_reset;
  logic next_core_reset;
  logic an_restart;
  logic next_an_restart;
  logic wr_ctl;
  logic wr_irq;

  logic lb_int;
  logic next_lb_int;
  logic lb_ext;
  logic next_lb_ext;
  logic pd_out;
  logic next_pd_out;

  // ============================================================
  // read decode
  assign hdr       = {sh[10:0], pins.mdio_lvl};
  assign hdr_match = (hdr[9:5] == phyad_i);

  always_comb begin
    rd_word = `SMR_VAL_ZERO;
    case (hdr[4:0])
      `SMR_ADDR_CONTROL: begin
        rd_word[`SMR_CTL_LOOPBACK]   = loopback;
        rd_word[`SMR_CTL_SPEED_LSB]  = `SMR_VAL_SPEED_LSB;
        rd_word[`SMR_CTL_AN_ENABLE]  = an_enable;
        rd_word[`SMR_CTL_POWER_DOWN] = power_down;
        rd_word[`SMR_CTL_ISOLATE]    = isolate;
        rd_word[`SMR_CTL_DUPLEX]     = `SMR_VAL_DUPLEX;
        rd_word[`SMR_CTL_COL_TEST]   = `SMR_VAL_COL_TEST;
        rd_word[`SMR_CTL_SPEED_MSB]  = `SMR_VAL_SPEED_MSB;
        rd_word[`SMR_CTL_UNIDIR]     = unidir;
      end
      `SMR_ADDR_STATUS: begin
        rd_word                      = `SMR_VAL_STATUS;
        rd_word[`SMR_STATUS_LINK]    = link_up_i;
      end
      `SMR_ADDR_ID_HIGH:     rd_word = ID_HIGH;
      `SMR_ADDR_ID_LOW:      rd_word = ID_LOW;
      `SMR_ADDR_ADVERT:      rd_word = `SMR_VAL_ADVERT;
      `SMR_ADDR_EXT_STATUS:  rd_word = `SMR_VAL_EXT_STATUS;
      `SMR_ADDR_IRQ_CONTROL: begin
        rd_word[`SMR_IRQ_STATUS]     = irq_status;
        rd_word[`SMR_IRQ_ENABLE]     = irq_enable;
      end
      default:               rd_word = `SMR_VAL_ZERO;
    endcase
  end

  // ============================================================
  // serial frame engine, acts on filtered clock rises only
  always_comb begin
    next_state    = state;
    next_cnt      = cnt;
    next_sh       = sh;
    next_is_rd    = is_rd;
    next_is_wr    = is_wr;
    next_wr_addr  = wr_addr;
    next_seen_one = seen_one;
    next_mdio_out = mdio_out;
    next_mdio_oe  = mdio_oe;
    next_wr_stb   = 1'b0;
    next_wr_data  = wr_data;
    if (pins.mdc_rise) begin
      case (state)
        SMR_IDLE: begin
          // preamble may be as short as one idle bit
          next_seen_one = pins.mdio_lvl;
          if (!pins.mdio_lvl && seen_one) begin
            next_state = SMR_START;
          end
        end
        SMR_START: begin
          if (pins.mdio_lvl) begin
            next_state = SMR_HEADER;
            next_cnt   = 5'h00;
          end else begin
            next_state    = SMR_IDLE;
            next_seen_one = 1'b0;
          end
        end
        SMR_HEADER: begin
          next_sh  = {sh[14:0], pins.mdio_lvl};
          next_cnt = cnt + 5'h01;
          if (cnt == `SMR_HDR_LAST) begin
            next_is_rd   = hdr_match && (hdr[11:10] == `SMR_OP_READ);
            next_is_wr   = hdr_match && (hdr[11:10] == `SMR_OP_WRITE);
            next_wr_addr = hdr[4:0];
            next_sh      = rd_word;
            next_cnt     = 5'h00;
            if ((hdr[11:10] == `SMR_OP_READ) || (hdr[11:10] == `SMR_OP_WRITE)) begin
              next_state = SMR_TURN;
            end else begin
              next_state    = SMR_IDLE;
              next_seen_one = 1'b0;
            end
          end
        end
        SMR_TURN: begin
          if (cnt == 5'h00) begin
            next_cnt = 5'h01;
            // second turnaround bit is driven low by the addressed device
            if (is_rd) begin
              next_mdio_oe  = 1'b1;
              next_mdio_out = 1'b0;
            end
          end else begin
            next_cnt   = 5'h00;
            next_state = SMR_DATA;
            if (is_rd) begin
              next_mdio_out = sh[15];
              next_sh       = {sh[14:0], 1'b0};
            end
          end
        end
        SMR_DATA: begin
          next_cnt = cnt + 5'h01;
          if (is_rd) begin
            next_mdio_out = sh[15];
            next_sh       = {sh[14:0], 1'b0};
          end else begin
            next_sh       = {sh[14:0], pins.mdio_lvl};
          end
          if (cnt == `SMR_DATA_LAST) begin
            next_mdio_oe  = 1'b0;
            next_mdio_out = 1'b0;
            next_wr_stb   = is_wr;
            next_wr_data  = {sh[14:0], pins.mdio_lvl};
            next_is_rd    = 1'b0;
            next_is_wr    = 1'b0;
            next_seen_one = 1'b0;
            next_state    = SMR_IDLE;
          end
        end
        default: begin
          next_state    = SMR_IDLE;
          next_mdio_oe  = 1'b0;
          next_seen_one = 1'b0;
        end
      endcase
    end
  end

  always_ff @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      state    <= SMR_IDLE;
      cnt      <= 5'h00;
      sh       <= 16'h0000;
      is_rd    <= 1'b0;
      is_wr    <= 1'b0;
      wr_addr  <= 5'h00;
      seen_one <= 1'b0;
      mdio_out <= 1'b0;
      mdio_oe  <= 1'b0;
      wr_stb   <= 1'b0;
      wr_data  <= 16'h0000;
    end else begin
      state    <= next_state;
      cnt      <= next_cnt;
      sh       <= next_sh;
      is_rd    <= next_is_rd;
      is_wr    <= next_is_wr;
      wr_addr  <= next_wr_addr;
      seen_one <= next_seen_one;
      mdio_out <= next_mdio_out;
      mdio_oe  <= next_mdio_oe;
      wr_stb   <= next_wr_stb;
      wr_data  <= next_wr_data;
    end
  end

  // ============================================================
  // control and interrupt registers
  assign wr_ctl = wr_stb && (wr_addr == `SMR_ADDR_CONTROL);
  assign wr_irq = wr_stb && (wr_addr == `SMR_ADDR_IRQ_CONTROL);

  always_comb begin
    next_loopback   = loopback;
    next_an_enable  = an_enable;
    next_power_down = power_down;
    next_isolate    = isolate;
    next_unidir     = unidir;
    next_irq_enable = irq_enable;
    next_irq_status = irq_status;
    next_core_reset = 1'b0;
    next_an_restart = 1'b0;
    // only named bits are stored; reserved and fixed bits of a write fall away
    if (wr_ctl) begin
      next_loopback  = wr_data[`SMR_CTL_LOOPBACK];
      next_an_enable = wr_data[`SMR_CTL_AN_ENABLE];
      next_isolate   = wr_data[`SMR_CTL_ISOLATE];
      next_unidir    = wr_data[`SMR_CTL_UNIDIR];
      if (wr_data[`SMR_CTL_POWER_DOWN]) begin
        next_power_down = 1'b1;
      end
      next_an_restart = wr_data[`SMR_CTL_AN_RESTART];
    end
    if (wr_irq) begin
      next_irq_enable = wr_data[`SMR_IRQ_ENABLE];
      // a one written here is a no-op, only completion sets the bit
      if (!wr_data[`SMR_IRQ_STATUS]) begin
        next_irq_status = 1'b0;
      end
    end
    // completion in the cycle of a clearing write still sets the flag
    if (an_complete_i) begin
      next_irq_status = 1'b1;
    end
    if (!next_irq_enable) begin
      next_irq_status = 1'b0;
    end
    // soft reset returns everything to defaults and is the only way out of power down
    if (wr_ctl && wr_data[`SMR_CTL_RESET]) begin
      next_core_reset = 1'b1;
      next_loopback   = `SMR_RST_LOOPBACK;
      next_an_enable  = `SMR_RST_AN_ENABLE;
      next_power_down = `SMR_RST_POWER_DOWN;
      next_isolate    = `SMR_RST_ISOLATE;
      next_unidir     = `SMR_RST_UNIDIR;
      next_irq_enable = `SMR_RST_IRQ_ENABLE;
      next_irq_status = `SMR_RST_IRQ_STATUS;
      next_an_restart = 1'b0;
    end
  end

  always_ff @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      loopback   <= `SMR_RST_LOOPBACK;
      an_enable  <= `SMR_RST_AN_ENABLE;
      power_down <= `SMR_RST_POWER_DOWN;
      isolate    <= `SMR_RST_ISOLATE;
      unidir     <= `SMR_RST_UNIDIR;
      irq_enable <= `SMR_RST_IRQ_ENABLE;
      irq_status <= `SMR_RST_IRQ_STATUS;
      core_reset <= 1'b0;
      an_restart <= 1'b0;
    end else begin
      loopback   <= next_loopback;
      an_enable  <= next_an_enable;
      power_down <= next_power_down;
      isolate    <= next_isolate;
      unidir     <= next_unidir;
      irq_enable <= next_irq_enable;
      irq_status <= next_irq_status;
      core_reset <= next_core_reset;
      an_restart <= next_an_restart;
    end
  end

  // ============================================================
  // option-dependent outputs, registered alongside the bits they follow
  always_comb begin
    next_lb_int = next_loopback & ~ten_bit_parallel_option_i;
    next_lb_ext = next_loopback & ten_bit_parallel_option_i;
    next_pd_out = next_power_down & ~ten_bit_parallel_option_i;
  end

  always_ff @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      lb_int <= 1'b0;
      lb_ext <= 1'b0;
      pd_out <= 1'b0;
    end else begin
      lb_int <= next_lb_int;
      lb_ext <= next_lb_ext;
      pd_out <= next_pd_out;
    end
  end

  // ============================================================
  // outputs
  assign mdio_o                     = mdio_out;
  assign mdio_oe_o                  = mdio_oe;
  assign core_reset_o               = core_reset;
  assign loopback_o                 = lb_int;
  assign external_wrap_o            = lb_ext;
  assign power_down_o               = pd_out;
  assign isolate_o                  = isolate;
  assign an_enable_o                = an_enable;
  assign an_restart_o               = an_restart;
  assign unidirectional_o           = unidir;
  assign negotiation_done_irq_out_o = irq_status;

endmodule

// file: testbench/smr_mdio_master.sv
`timescale 1ns/10ps

module smr_mdio_master (
  // clock
  input  wire logic clk_i,
  // resolved data line
  input  wire logic line_i,
  // management pins
  output logic      mdc_o,
  output logic      drv_o,
  output logic      oe_o
);
  // management clock stands low between frames
  initial begin
    mdc_o = 1'h0;
    drv_o = 1'h1;
    oe_o  = 1'h0;
  end

  // ==========================================================
  // one bit: data changes with mdc low, line sampled just before the rise
  task automatic bit_io(input logic b, input logic en, output logic s);
    oe_o  = en;
    drv_o = b;
    repeat (10) @(negedge clk_i);
    s     = line_i;
    mdc_o = 1'h1;
    repeat (10) @(negedge clk_i);
    mdc_o = 1'h0;
  endtask

  // ==========================================================
  // medium link figures are never asked of this device, only its own registers
  task automatic frame(input logic [1:0] op, input logic [4:0] pa, input logic [4:0] ra,
                       input logic [15:0] wd, output logic [15:0] rd);
    logic        s;
    logic [31:0] f;
    int          i;
    f = {2'h1, op, pa, ra, 2'h2, wd};
    rd = 16'h0000;
    bit_io(1'h1, 1'h1, s);
    bit_io(1'h1, 1'h1, s);
    for (i = 31; i >= 0; i--) begin
      // a read hands the line over from the first turnaround bit on
      bit_io(f[i], !(op == 2'h2 && i <= 17), s);
      if (i < 16) rd[i] = s;
    end
    oe_o = 1'h0;
    // one spare clock, so a following frame never re-drives the enable in this time step
    @(negedge clk_i);
  endtask
endmodule

// file: testbench/smr_mgmt_regs_asserts.sv
`timescale 1ns/10ps

module smr_mgmt_regs_asserts (
  // clock and reset
  input  wire logic               clk_i,
  input  wire logic               rst_b_i,
  // management pins
  input  wire logic               mdc_i,
  input  wire logic               mdio_i,
  input  wire logic               mdio_o,
  input  wire logic               mdio_oe_o,
  input  wire smr_pkg::smr_addr_t phyad_i,
  // core status
  input  wire logic               an_complete_i,
  input  wire logic               link_up_i,
  input  wire logic               ten_bit_parallel_option_i,
  // core control
  input  wire logic               core_reset_o,
  input  wire logic               loopback_o,
  input  wire logic               external_wrap_o,
  input  wire logic               power_down_o,
  input  wire logic               isolate_o,
  input  wire logic               an_enable_o,
  input  wire logic               an_restart_o,
  input  wire logic               unidirectional_o,
  input  wire logic               negotiation_done_irq_out_o
);
  import smr_pkg::*;

  // ==========================================================
  // cycles since the last mdc pin rise; register writes land a few cycles after one
  logic       mdc_q;
  logic [4:0] age;
  logic [4:0] next_age;

  always_comb begin
    next_age = (age == 5'h1F) ? age : age + 5'h01;
    if (mdc_i && !mdc_q) next_age = 5'h00;
  end

  always_ff @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      mdc_q <= 1'h0;
      age   <= 5'h1F;
    end else begin
      mdc_q <= mdc_i;
      age   <= next_age;
    end
  end

  default clocking @(posedge clk_i); endclocking
  default disable iff (!rst_b_i);

  // ==========================================================
  chk_reset_pulse:
    assert property (core_reset_o |-> (age >= 5'h02 && age <= 5'h0C) ##1 !core_reset_o)
      else $error("core reset pulse badly timed or too long");
  chk_restart_pulse:
    assert property (an_restart_o |-> (age >= 5'h02 && age <= 5'h0C) ##1 !an_restart_o)
      else $error("restart pulse badly timed or too long");
  chk_soft_defaults:
    assert property (core_reset_o |-> ##[0:1] (isolate_o && an_enable_o && !loopback_o && !external_wrap_o
                     && !power_down_o && !unidirectional_o && !negotiation_done_irq_out_o))
      else $error("soft reset left a control output off its default");
  chk_wrap_select:
    assert property ((loopback_o || external_wrap_o) |->
                     (external_wrap_o == $past(ten_bit_parallel_option_i) && loopback_o != external_wrap_o))
      else $error("loopback routed to the wrong option output");
  chk_pd_option:
    assert property (power_down_o |-> !$past(ten_bit_parallel_option_i))
      else $error("power down active with parallel option");
  chk_pd_clear:
    assert property ($fell(power_down_o) |-> (core_reset_o || $past(core_reset_o)
                     || $past(ten_bit_parallel_option_i)))
      else $error("power down cleared without soft reset");
  chk_irq_set:
    assert property ($rose(negotiation_done_irq_out_o) |-> $past(an_complete_i))
      else $error("interrupt rose without completion");
  chk_irq_clear:
    assert property ($fell(negotiation_done_irq_out_o) |-> (age >= 5'h02 && age <= 5'h0C))
      else $error("interrupt cleared outside a register write");
  chk_ctl_timing:
    assert property (($changed(isolate_o) || $changed(an_enable_o) || $changed(unidirectional_o))
                     |-> (age >= 5'h02 && age <= 5'h0C))
      else $error("control output changed outside a register write");
endmodule

bind smr_mgmt_regs smr_mgmt_regs_asserts u_chk (
  .clk_i(clk_i), .rst_b_i(rst_b_i), .mdc_i(mdc_i), .mdio_i(mdio_i), .mdio_o(mdio_o),
  .mdio_oe_o(mdio_oe_o), .phyad_i(phyad_i), .an_complete_i(an_complete_i), .link_up_i(link_up_i),
  .ten_bit_parallel_option_i(ten_bit_parallel_option_i), .core_reset_o(core_reset_o),
  .loopback_o(loopback_o), .external_wrap_o(external_wrap_o), .power_down_o(power_down_o),
  .isolate_o(isolate_o), .an_enable_o(an_enable_o), .an_restart_o(an_restart_o),
  .unidirectional_o(unidirectional_o), .negotiation_done_irq_out_o(negotiation_done_irq_out_o)
);

// file: testbench/sgmii_mgmt_control_regs_test.sv
`timescale 1ns/10ps

module sgmii_mgmt_control_regs_test;
  import smr_pkg::*;

  // identifier words are arbitrary
  localparam smr_word_t ID_HI = 16'h5A3C;
  localparam smr_word_t ID_LO = 16'hC3A5;
  localparam smr_addr_t PHY   = 5'h09;

  logic      clk_i, rst_b_i, an_complete_i, link_up_i, opt_i, mdio_i;
  logic      mdc, m_drv, m_oe, mdio_o, mdio_oe_o, core_reset_o, loopback_o, external_wrap_o;
  logic      power_down_o, isolate_o, an_enable_o, an_restart_o, unidirectional_o, irq_o;
  int        n_mismatch, samples_checked, n_rst, n_rs, seed, a;
  int        lb, ane, pd, iso, uni, ien, ist, e_rst, e_rs;
  smr_word_t d;

  // pull-up on the shared data line
  assign mdio_i = mdio_oe_o ? mdio_o : (m_oe ? m_drv : 1'h1);

  initial begin
    clk_i = 1'h0;
    forever #10 clk_i = ~clk_i;
  end

  smr_mgmt_regs #(.ID_HIGH(ID_HI), .ID_LOW(ID_LO)) u_dut (
    .clk_i(clk_i), .rst_b_i(rst_b_i), .mdc_i(mdc), .mdio_i(mdio_i), .mdio_o(mdio_o),
    .mdio_oe_o(mdio_oe_o), .phyad_i(PHY), .an_complete_i(an_complete_i), .link_up_i(link_up_i),
    .ten_bit_parallel_option_i(opt_i), .core_reset_o(core_reset_o), .loopback_o(loopback_o),
    .external_wrap_o(external_wrap_o), .power_down_o(power_down_o), .isolate_o(isolate_o),
    .an_enable_o(an_enable_o), .an_restart_o(an_restart_o), .unidirectional_o(unidirectional_o),
    .negotiation_done_irq_out_o(irq_o));

  smr_mdio_master u_mst (.clk_i(clk_i), .line_i(mdio_i), .mdc_o(mdc), .drv_o(m_drv), .oe_o(m_oe));

  always @(posedge clk_i) begin
    if (core_reset_o === 1'h1) n_rst++;
    if (an_restart_o === 1'h1) n_rs++;
  end

  // ==========================================================
  task automatic check(input smr_word_t got, input smr_word_t exp);
    samples_checked++;
    if (got !== exp) begin
      n_mismatch++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic end_of_test();
    $display("checks=%0d mismatches=%0d", samples_checked, n_mismatch);
    if (n_mismatch == 0 && samples_checked > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask

  task automatic defaults();
    lb  = 0;
    ane = 1;
    pd  = 0;
    iso = 1;
    uni = 0;
    ien = 1;
    ist = 0;
  endtask

  function automatic smr_word_t exp_rd(input int ad);
    case (ad)
      0:       return {1'h0, lb[0], 1'h0, ane[0], pd[0], iso[0], 2'h1, 2'h1, uni[0], 5'h00};
      1:       return 16'h01C0 | {13'h0000, link_up_i, 2'h0};
      2:       return ID_HI;
      3:       return ID_LO;
      4:       return 16'h0001;
      15:      return 16'h8000;
      16:      return {14'h0000, ist[0], ien[0]};
      default: return 16'h0000;
    endcase
  endfunction

  task automatic chk_outs();
    check({9'h000, loopback_o, external_wrap_o, power_down_o, isolate_o, an_enable_o, unidirectional_o, irq_o},
          {9'h000, lb[0] & ~opt_i, lb[0] & opt_i, pd[0] & ~opt_i, iso[0], ane[0], uni[0], ist[0]});
    check(n_rst[15:0], e_rst[15:0]);
    check(n_rs[15:0], e_rs[15:0]);
  endtask

  // model follows each write before outputs are compared
  task automatic wr(input int ad, input smr_word_t wd);
    smr_word_t x;
    u_mst.frame(2'h1, PHY, ad[4:0], wd, x);
    repeat (4) @(negedge clk_i);
    if (ad == 0 && wd[15]) begin
      defaults();
      e_rst++;
    end else if (ad == 0) begin
      lb   = wd[14];
      ane  = wd[12];
      pd  |= wd[11];
      iso  = wd[10];
      uni  = wd[5];
      e_rs += wd[9];
    end else if (ad == 16) begin
      ien = wd[0];
      ist = ist & wd[1] & wd[0];
    end
    chk_outs();
  endtask

  task automatic rd_chk(input int ad);
    smr_word_t x;
    u_mst.frame(2'h2, PHY, ad[4:0], 16'h0000, x);
    check(x, exp_rd(ad));
  endtask

  task automatic an_event();
    an_complete_i = 1'h1;
    @(negedge clk_i);
    an_complete_i = 1'h0;
    ist |= ien;
    @(negedge clk_i);
    chk_outs();
  endtask

  // ==========================================================
  initial begin
    seed          = 32'hFBB21D46;
    rst_b_i       = 1'h0;
    an_complete_i = 1'h0;
    link_up_i     = 1'h1;
    opt_i         = 1'h0;
    defaults();
    repeat (10) @(negedge clk_i);
    rst_b_i = 1'h1;
    @(negedge clk_i);
    chk_outs();
    for (a = 0; a <= 17; a++) rd_chk(a);
    rd_chk(31);
    $display("test 1 reset map done");
    for (a = 0; a < 6; a++) begin
      opt_i     = a[0];
      link_up_i = 1'($random(seed));
      d         = 16'($random(seed));
      d[15]     = 1'h0;
      wr(0, d);
      rd_chk(0);
      rd_chk(1);
    end
    $display("test 2 control fields done");
    opt_i = 1'h0;
    wr(0, 16'h0800);
    wr(0, 16'h1200);
    rd_chk(0);
    wr(0, 16'h8000);
    rd_chk(0);
    $display("test 3 power down and soft reset done");
    an_event();
    wr(16, 16'h0003);
    rd_chk(16);
    wr(16, 16'hFFFD);
    rd_chk(16);
    wr(16, 16'h0002);
    an_event();
    rd_chk(16);
    wr(16, 16'h0001);
    an_event();
    wr(0, 16'h8000);
    rd_chk(16);
    $display("test 4 interrupt done");
    wr(5, 16'($random(seed)));
    wr(31, 16'hFFFF);
    rd_chk(5);
    rd_chk(0);
    u_mst.frame(2'h1, PHY ^ 5'h01, 5'h00, 16'h4000, d);
    repeat (4) @(negedge clk_i);
    chk_outs();
    u_mst.frame(2'h2, PHY ^ 5'h01, 5'h00, 16'h0000, d);
    check(d, 16'hFFFF);
    // op 00 is neither read nor write, so nothing may be stored from this frame
    u_mst.frame(2'h0, PHY, 5'h00, 16'h4400, d);
    repeat (4) @(negedge clk_i);
    chk_outs();
    $display("test 5 undefined and foreign frames done");
    end_of_test();
  end

  initial begin
    repeat (90000) @(posedge clk_i);
    n_mismatch++;
    end_of_test();
  end
endmodule
